//--- i2c_config_pkg.sv
package i2c_config_pkg;

	// clock and bus rate figures
	localparam int unsigned CLK_HZ         = 100_000_000; // core clock rate
	localparam int unsigned SCL_MIN_HZ     = 50_000;      // slowest bus clock
	localparam int unsigned SCL_MAX_HZ     = 1_000_000;   // fastest bus clock
	localparam int unsigned SCL_MIN_PERIOD = CLK_HZ / SCL_MAX_HZ; // core cycles per fastest bit
	localparam int unsigned SYNC_STAGES    = 3;           // pin synchroniser depth

	// register offsets
	localparam logic [7:0] ADDR_NVM_STORE   = 8'h15; // store to nvm
	localparam logic [7:0] ADDR_NVM_RESTORE = 8'h16; // restore from nvm
	localparam logic [7:0] ADDR_TURN_ON_DELAY   = 8'h60; // turn-on delay
	localparam logic [7:0] ADDR_TON_RAMP    = 8'h61; // turn-on ramp time
	localparam logic [7:0] ADDR_TURN_OFF_DELAY  = 8'h64; // turn-off delay
	localparam logic [7:0] ADDR_TOFF_RAMP   = 8'h65; // turn-off ramp time
	localparam logic [7:0] ADDR_SYS_CFG     = 8'hA0; // system config one
	localparam logic [7:0] ADDR_VR_ADDR     = 8'hA1; // vr bus address
	localparam logic [7:0] ADDR_PROG_ADDR   = 8'hA2; // programmed target address
	localparam logic [7:0] ADDR_OFFSET      = 8'hA8; // setpoint offset
	localparam logic [7:0] ADDR_LOCK        = 8'hB1; // write lock register
	localparam logic [7:0] ADDR_MAX_HI      = 8'hBD; // max setpoint high
	localparam logic [7:0] ADDR_MAX_LO      = 8'hBE; // max setpoint low
	localparam logic [7:0] ADDR_PROTOCOL    = 8'hC2; // vr protocol select

	// system config field layout
	localparam int unsigned SYS_TGT_OVRD_BIT = 0;     // target_address_override
	localparam int unsigned SYS_VR_OVRD_BIT  = 1;     // vr_bus_address_override
	localparam int unsigned SYS_SRC_LSB      = 3;     // setpoint_source low bit
	localparam logic [7:0]  SYS_OVRD_MASK    = 8'h03; // power-cycle-only bits
	localparam logic [7:0]  SYS_STAGED_MASK  = 8'hFC; // forced_continuous_mode, source, soft stop, ready delay
	localparam logic [1:0]  SRC_STAGED_CODE  = 2'h1;  // source code that stages the offset
	localparam logic [7:0]  PROT_STAGED_MASK = 8'h03; // broadcast select field

	// addressing and command fields
	localparam logic [6:0] STRAP_BASE_ADDR = 7'h70; // strap decode base
	localparam logic       DIR_WRITE       = 1'b0;  // direction bit for write
	localparam int unsigned STORE_GO_BIT   = 0;     // store trigger bit
	localparam logic [7:0] RD_ZERO         = 8'h00; // read value of write-only or unmapped

	// write lock passcode sequence, index 0 first
	localparam int unsigned LOCK_STEPS = 3; // passcodes in sequence
	localparam logic [LOCK_STEPS-1:0][7:0] LOCK_PASSCODES = {8'hC3, 8'h5A, 8'hA5};

	// power-on wait before strap capture and nvm load
	localparam logic [2:0] INIT_WAIT = 3'h5; // covers synchroniser and filter

	// one set of storable settings
	typedef struct packed
	{
		logic [7:0] turn_on_delay;  // turn_on_delay
		logic [7:0] ton_ramp;   // turn_on_ramp_time
		logic [7:0] turn_off_delay; // turn_off_delay
		logic [7:0] toff_ramp;  // turn_off_ramp_time
		logic [7:0] max_hi;     // max_setpoint_high
		logic [7:0] max_lo;     // max_setpoint_low
		logic [7:0] sys_cfg;    // system_config_one
		logic [7:0] vr_addr;    // vr_bus_address
		logic [7:0] prog_addr;  // programmed or active target address
		logic [7:0] offset;     // setpoint_offset
		logic [7:0] protocol;   // vr_protocol_select
	} reg_set_t;

	// bus engine states, one-hot
	typedef enum logic [8:0]
	{
		ST_IDLE  = 9'b0_0000_0001,
		ST_ADDR  = 9'b0_0000_0010,
		ST_AACK  = 9'b0_0000_0100,
		ST_CMD   = 9'b0_0000_1000,
		ST_CACK  = 9'b0_0001_0000,
		ST_WDATA = 9'b0_0010_0000,
		ST_WACK  = 9'b0_0100_0000,
		ST_RDATA = 9'b0_1000_0000,
		ST_RACK  = 9'b1_0000_0000
	} state_t;

endpackage

//--- i2c_config_access.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE1] bus runs from 50 kHz to 1 MHz
// [RULE2] nvm written only by explicit store command
// [RULE3] controller sends no packet error checking byte
// [RULE4] default address from strap decode 0x70-0x7F
// [RULE5] programmed address accepts full 7-bit range
// [RULE6] override bit selects programmed address instead
// [RULE7] controller writes address, override, stores, power cycles
// [RULE8] first byte holds address and direction bit
// [RULE9] writes are refused after power-on until unlocked
// [RULE10] reads always acknowledged with register data
// [RULE11] correct passcode sequence at lock register unlocks
// [RULE12] ordinary writes take effect at once
// [RULE13] protected registers refuse writes while switching
// [RULE14] always-on config blocks restore of protected registers
// [RULE15] staged fields apply only when switching stops
// [RULE16] staged register reads return last accepted value
// [RULE17] staged fields listed, offset only for source 01
// [RULE18] always-on restore may leave staged values pending
// [RULE19] address override and address apply at power-on only
// [RULE20] refused writes leave stored contents unchanged
module i2c_config_access
	import i2c_config_pkg::*;
(
	input  wire logic       clk_i,          // core clock
	input  wire logic       rst_n_i,        // synchronous reset, active low
	input  wire logic       scl_i,          // bus clock pin level
	input  wire logic       sda_i,          // bus data pin level
	output logic            sda_o,          // bus data drive value, always low
	output logic            sda_oe_n_o,     // bus data enable, low pulls line
	input  wire logic [3:0] strap_code_i,   // strap resistor decode code
	input  wire logic       switching_en_i, // power switching running
	input  wire logic       always_on_i,    // turn-on source set to always on
	input  wire reg_set_t   nvm_rdata_i,    // settings held in nvm
	output logic            nvm_store_o,    // store pulse to nvm
	output reg_set_t        nvm_wdata_o,    // settings to store
	output reg_set_t        cfg_o,          // settings in effect
	output logic            locked_o        // write lock active
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and glitch filter

	logic [SYNC_STAGES-1:0]      scl_sync_reg;   // scl shift chain
	logic [SYNC_STAGES-1:0]      sda_sync_reg;   // sda shift chain
	logic [SYNC_STAGES-1:0][3:0] strap_sync_reg; // strap shift chain
	logic                        scl_filt_reg;   // accepted scl level
	logic                        sda_filt_reg;   // accepted sda level
	logic [3:0]                  strap_filt_reg; // accepted strap code
	logic                        scl_last_reg;   // scl level one cycle ago
	logic                        sda_last_reg;   // sda level one cycle ago

	// three-stage chains, level taken when last two agree
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			scl_sync_reg   <= '1;
			sda_sync_reg   <= '1;
			strap_sync_reg <= '0;
			scl_filt_reg   <= 1'b1;
			sda_filt_reg   <= 1'b1;
			strap_filt_reg <= 4'h0;
			scl_last_reg   <= 1'b1;
			sda_last_reg   <= 1'b1;
		end
		else
		begin
			scl_sync_reg   <= {scl_sync_reg[SYNC_STAGES-2:0], scl_i};
			sda_sync_reg   <= {sda_sync_reg[SYNC_STAGES-2:0], sda_i};
			strap_sync_reg <= {strap_sync_reg[SYNC_STAGES-2:0], strap_code_i};
			// agreement filter rejects single-sample spikes at up to 1 MHz [RULE1]
			if (scl_sync_reg[1] == scl_sync_reg[2])
				scl_filt_reg <= scl_sync_reg[2];
			if (sda_sync_reg[1] == sda_sync_reg[2])
				sda_filt_reg <= sda_sync_reg[2];
			if (strap_sync_reg[1] == strap_sync_reg[2])
				strap_filt_reg <= strap_sync_reg[2];
			scl_last_reg <= scl_filt_reg;
			sda_last_reg <= sda_filt_reg;
		end
	end

	// bus events from filtered levels
	logic scl_rise; // scl went high
	logic scl_fall; // scl went low
	logic bus_start; // sda fell while scl high
	logic bus_stop;  // sda rose while scl high

	assign scl_rise  = scl_filt_reg & ~scl_last_reg;
	assign scl_fall  = ~scl_filt_reg & scl_last_reg;
	assign bus_start = scl_filt_reg & scl_last_reg & sda_last_reg & ~sda_filt_reg;
	assign bus_stop  = scl_filt_reg & scl_last_reg & ~sda_last_reg & sda_filt_reg;

	////////////////////////////////////////////////////////////////////////////////
	// power-on initialisation

	logic [2:0] init_cnt_reg;  // cycles since reset release
	logic       init_done_reg; // nvm load finished
	logic       init_go;       // one-cycle power-on load

	assign init_go = (init_cnt_reg == INIT_WAIT) & ~init_done_reg;

	// wait for strap filter to settle, then load once
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			init_cnt_reg  <= 3'h0;
			init_done_reg <= 1'b0;
		end
		else if (!init_done_reg)
		begin
			init_cnt_reg  <= init_cnt_reg + 3'h1;
			init_done_reg <= init_go;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state shared by bus engine and register file

	reg_set_t   shadow_reg; // last accepted values, read back
	reg_set_t   eff_reg;    // values in effect
	logic       locked_reg; // write lock
	logic [7:0] cmd_reg;    // register pointer
	logic       wr_stb_reg; // accepted data byte pulse
	logic [7:0] wr_data_reg; // last received data byte, accepted or not

	// registers that refuse writes while switching
	logic protected_cmd;
	assign protected_cmd = (cmd_reg == ADDR_NVM_RESTORE) || (cmd_reg == ADDR_TURN_ON_DELAY)
		|| (cmd_reg == ADDR_TON_RAMP) || (cmd_reg == ADDR_TURN_OFF_DELAY)
		|| (cmd_reg == ADDR_TOFF_RAMP) || (cmd_reg == ADDR_MAX_HI)
		|| (cmd_reg == ADDR_MAX_LO);

	// write acceptance for the current pointer
	logic wr_accept;
	always_comb
	begin
		if (cmd_reg == ADDR_LOCK)
			wr_accept = 1'b1;                 // passcodes always taken [RULE11]
		else if (locked_reg)
			wr_accept = 1'b0;                 // locked writes refused [RULE9]
		else if (protected_cmd && switching_en_i)
			wr_accept = 1'b0;                 // refused while switching [RULE13]
		else
			wr_accept = 1'b1;
	end

	// readback selects accepted values, not effective ones
	logic [7:0] rd_byte;
	always_comb
	begin
		case (cmd_reg)
			ADDR_TURN_ON_DELAY:  rd_byte = shadow_reg.turn_on_delay;
			ADDR_TON_RAMP:   rd_byte = shadow_reg.ton_ramp;
			ADDR_TURN_OFF_DELAY: rd_byte = shadow_reg.turn_off_delay;
			ADDR_TOFF_RAMP:  rd_byte = shadow_reg.toff_ramp;
			ADDR_MAX_HI:     rd_byte = shadow_reg.max_hi;
			ADDR_MAX_LO:     rd_byte = shadow_reg.max_lo;
			ADDR_SYS_CFG:    rd_byte = shadow_reg.sys_cfg;   // [RULE16]
			ADDR_VR_ADDR:    rd_byte = shadow_reg.vr_addr;   // [RULE16]
			ADDR_PROG_ADDR:  rd_byte = shadow_reg.prog_addr;
			ADDR_OFFSET:     rd_byte = shadow_reg.offset;    // [RULE16]
			ADDR_PROTOCOL:   rd_byte = shadow_reg.protocol;  // [RULE16]
			ADDR_LOCK:       rd_byte = {7'h00, locked_reg};
			default:         rd_byte = RD_ZERO;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus target engine

	state_t     state_reg;  // engine state
	logic [3:0] bit_cnt_reg; // bits in current byte
	logic [7:0] rx_reg;     // receive shifter
	logic [7:0] tx_reg;     // transmit shifter
	logic       rd_dir_reg; // read transfer
	logic       mack_reg;   // controller acked read byte
	logic       sda_drv_reg; // pull sda low
	logic       addr_match;  // address byte is ours

	// address byte bits 7:1 against active address, bit 0 direction [RULE8]
	assign addr_match = init_done_reg && (rx_reg[7:1] == eff_reg.prog_addr[6:0]);

	// start and stop win over bit handling
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_reg   <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			rx_reg      <= 8'h00;
			tx_reg      <= 8'h00;
			rd_dir_reg  <= 1'b0;
			mack_reg    <= 1'b0;
			sda_drv_reg <= 1'b0;
			cmd_reg     <= 8'h00;
			wr_stb_reg  <= 1'b0;
			wr_data_reg <= 8'h00;
		end
		else
		begin
			wr_stb_reg <= 1'b0;
			if (bus_stop)
			begin
				state_reg   <= ST_IDLE;    // release and wait
				sda_drv_reg <= 1'b0;
			end
			else if (bus_start)
			begin
				state_reg   <= ST_ADDR;    // also repeated start
				bit_cnt_reg <= 4'h0;
				sda_drv_reg <= 1'b0;
			end
			else if (scl_rise)
			begin
				case (state_reg)
					ST_ADDR, ST_CMD, ST_WDATA:
					begin
						rx_reg      <= {rx_reg[6:0], sda_filt_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					ST_RACK: mack_reg <= ~sda_filt_reg; // low means more wanted
					default: ;
				endcase
			end
			else if (scl_fall)
			begin
				case (state_reg)
					ST_ADDR:
						if (bit_cnt_reg == 4'h8)
						begin
							bit_cnt_reg <= 4'h0;
							if (addr_match)
							begin
								sda_drv_reg <= 1'b1;
								rd_dir_reg  <= (rx_reg[0] != DIR_WRITE); // [RULE8]
								state_reg   <= ST_AACK;
							end
							else
								state_reg <= ST_IDLE; // other target
						end
					ST_AACK:
						if (rd_dir_reg)
						begin
							// reads answered whatever the lock [RULE10]
							sda_drv_reg <= ~rd_byte[7];
							tx_reg      <= {rd_byte[6:0], 1'b0};
							bit_cnt_reg <= 4'h1;
							state_reg   <= ST_RDATA;
						end
						else
						begin
							sda_drv_reg <= 1'b0;
							state_reg   <= ST_CMD;
						end
					ST_CMD:
						if (bit_cnt_reg == 4'h8)
						begin
							bit_cnt_reg <= 4'h0;
							cmd_reg     <= rx_reg;
							sda_drv_reg <= 1'b1;
							state_reg   <= ST_CACK;
						end
					ST_CACK, ST_WACK:
					begin
						sda_drv_reg <= 1'b0;
						state_reg   <= ST_WDATA;
					end
					ST_WDATA:
						if (bit_cnt_reg == 4'h8)
						begin
							bit_cnt_reg <= 4'h0;
							sda_drv_reg <= wr_accept;  // nack leaves line high
							wr_stb_reg  <= wr_accept;  // refused byte stores nothing [RULE20]
							wr_data_reg <= rx_reg;
							state_reg   <= ST_WACK;
						end
					ST_RDATA:
						if (bit_cnt_reg == 4'h8)
						begin
							sda_drv_reg <= 1'b0;       // free line for controller ack
							mack_reg    <= 1'b0;
							state_reg   <= ST_RACK;
						end
						else
						begin
							sda_drv_reg <= ~tx_reg[7];
							tx_reg      <= {tx_reg[6:0], 1'b0};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					ST_RACK:
						if (mack_reg)
						begin
							sda_drv_reg <= ~rd_byte[7]; // same register again
							tx_reg      <= {rd_byte[6:0], 1'b0};
							bit_cnt_reg <= 4'h1;
							state_reg   <= ST_RDATA;
						end
						else
							state_reg <= ST_IDLE;
					ST_IDLE: ;
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write lock

	logic [1:0] lock_step_reg; // passcodes matched so far

	// ordered passcodes unlock; any lock register write while unlocked relocks
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			locked_reg    <= 1'b1;                 // locked after power-on [RULE9]
			lock_step_reg <= 2'h0;
		end
		else if (wr_stb_reg && (cmd_reg == ADDR_LOCK))
		begin
			if (!locked_reg)
			begin
				locked_reg    <= 1'b1;
				lock_step_reg <= 2'h0;
			end
			else if (wr_data_reg != LOCK_PASSCODES[lock_step_reg])
				lock_step_reg <= 2'h0;                 // wrong code restarts [RULE11]
			else if (lock_step_reg == 2'(LOCK_STEPS - 1))
			begin
				locked_reg    <= 1'b0;                 // sequence complete [RULE11]
				lock_step_reg <= 2'h0;
			end
			else
				lock_step_reg <= lock_step_reg + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// accepted values and nvm restore

	logic restore_go; // load shadow from nvm
	assign restore_go = init_go | (wr_stb_reg && (cmd_reg == ADDR_NVM_RESTORE));

	// shadow follows accepted writes and restores
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			shadow_reg <= '0;
		else if (restore_go)
		begin
			// staged and address fields may sit here unused [RULE18]
			shadow_reg.sys_cfg   <= nvm_rdata_i.sys_cfg;
			shadow_reg.vr_addr   <= nvm_rdata_i.vr_addr;
			shadow_reg.prog_addr <= nvm_rdata_i.prog_addr;
			shadow_reg.offset    <= nvm_rdata_i.offset;
			shadow_reg.protocol  <= nvm_rdata_i.protocol;
			if (!always_on_i)
			begin
				// protected values rejected under always-on [RULE14]
				shadow_reg.turn_on_delay  <= nvm_rdata_i.turn_on_delay;
				shadow_reg.ton_ramp   <= nvm_rdata_i.ton_ramp;
				shadow_reg.turn_off_delay <= nvm_rdata_i.turn_off_delay;
				shadow_reg.toff_ramp  <= nvm_rdata_i.toff_ramp;
				shadow_reg.max_hi     <= nvm_rdata_i.max_hi;
				shadow_reg.max_lo     <= nvm_rdata_i.max_lo;
			end
		end
		else if (wr_stb_reg)
		begin
			case (cmd_reg)
				ADDR_TURN_ON_DELAY:  shadow_reg.turn_on_delay  <= wr_data_reg;
				ADDR_TON_RAMP:   shadow_reg.ton_ramp   <= wr_data_reg;
				ADDR_TURN_OFF_DELAY: shadow_reg.turn_off_delay <= wr_data_reg;
				ADDR_TOFF_RAMP:  shadow_reg.toff_ramp  <= wr_data_reg;
				ADDR_MAX_HI:     shadow_reg.max_hi     <= wr_data_reg;
				ADDR_MAX_LO:     shadow_reg.max_lo     <= wr_data_reg;
				ADDR_SYS_CFG:    shadow_reg.sys_cfg    <= wr_data_reg;
				ADDR_VR_ADDR:    shadow_reg.vr_addr    <= wr_data_reg;
				ADDR_PROG_ADDR:  shadow_reg.prog_addr  <= {1'b0, wr_data_reg[6:0]}; // [RULE5]
				ADDR_OFFSET:     shadow_reg.offset     <= wr_data_reg;
				ADDR_PROTOCOL:   shadow_reg.protocol   <= wr_data_reg;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// values in effect

	logic       hold;          // switching running, staged fields frozen
	logic       offset_staged; // offset follows staging rule
	logic [7:0] sys_ovrd_next; // override bits in effect
	logic [6:0] active_addr;   // address chosen at power-on

	assign hold          = switching_en_i;
	assign offset_staged = (shadow_reg.sys_cfg[SYS_SRC_LSB +: 2] == SRC_STAGED_CODE); // [RULE17]
	// override selects programmed address, else strap code [RULE4] [RULE6]
	assign active_addr   = nvm_rdata_i.sys_cfg[SYS_TGT_OVRD_BIT] ?
		nvm_rdata_i.prog_addr[6:0] : (STRAP_BASE_ADDR | {3'h0, strap_filt_reg});
	// override bits change only by power-on load [RULE19]
	assign sys_ovrd_next = init_go ? (nvm_rdata_i.sys_cfg & SYS_OVRD_MASK)
		: (eff_reg.sys_cfg & SYS_OVRD_MASK);

	// immediate, staged and power-on-only fields
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			eff_reg <= '0;
		else
		begin
			// ordinary registers follow accepted values [RULE12]
			eff_reg.turn_on_delay  <= shadow_reg.turn_on_delay;
			eff_reg.ton_ramp   <= shadow_reg.ton_ramp;
			eff_reg.turn_off_delay <= shadow_reg.turn_off_delay;
			eff_reg.toff_ramp  <= shadow_reg.toff_ramp;
			eff_reg.max_hi     <= shadow_reg.max_hi;
			eff_reg.max_lo     <= shadow_reg.max_lo;
			// staged fields wait while switching [RULE15] [RULE17]
			eff_reg.sys_cfg <= sys_ovrd_next | ((hold ? eff_reg.sys_cfg : shadow_reg.sys_cfg)
				& SYS_STAGED_MASK);
			eff_reg.vr_addr <= hold ? eff_reg.vr_addr : shadow_reg.vr_addr;
			eff_reg.protocol <= (shadow_reg.protocol & ~PROT_STAGED_MASK)
				| ((hold ? eff_reg.protocol : shadow_reg.protocol) & PROT_STAGED_MASK);
			eff_reg.offset <= (hold && offset_staged) ? eff_reg.offset : shadow_reg.offset;
			if (init_go)
				eff_reg.prog_addr <= {1'b0, active_addr}; // [RULE19]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// nvm store and pin outputs

	// store only on explicit command, never on plain writes [RULE2]
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			nvm_store_o <= 1'b0;
			nvm_wdata_o <= '0;
		end
		else
		begin
			nvm_store_o <= wr_stb_reg && (cmd_reg == ADDR_NVM_STORE)
				&& wr_data_reg[STORE_GO_BIT];
			nvm_wdata_o <= shadow_reg;
		end
	end

	// open-drain drive and status outputs
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			sda_o      <= 1'b0;
			sda_oe_n_o <= 1'b1;
			cfg_o      <= '0;
			locked_o   <= 1'b1;
		end
		else
		begin
			sda_o      <= 1'b0;
			sda_oe_n_o <= ~sda_drv_reg;
			cfg_o      <= eff_reg;
			locked_o   <= locked_reg;
		end
	end

endmodule

//--- i2c_config_chk.sv
`timescale 1ns/1ps
module i2c_config_chk
	import i2c_config_pkg::*;
(
	input wire logic     clk_i,          // core clock
	input wire logic     rst_n_i,        // reset, active low
	input wire logic     scl_i,          // bus clock pin
	input wire logic     switching_en_i, // switching running
	input wire logic     sda_o,          // data drive value
	input wire logic     sda_oe_n_o,     // low pulls data
	input wire logic     nvm_store_o,    // store pulse
	input wire reg_set_t cfg_o,          // settings in effect
	input wire logic     locked_o        // write lock
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////
	logic [5:0] init_cnt_reg; // cycles since reset release
	logic       init_done;    // power-on load long over
	// saturating count, masks the power-on load
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			init_cnt_reg <= 6'h00;
		else if (!init_done)
			init_cnt_reg <= init_cnt_reg + 6'h01;
	end
	assign init_done = (init_cnt_reg == 6'h28);
	// switching held over the staging lag
	sequence sw_run;
		switching_en_i [*3];
	endsequence
	////////////////////////////////////////////////////////////////
	chk_drive_low_only: assert property (!sda_oe_n_o |-> !sda_o)
		else $error("data driven high");
	chk_sda_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
		else $error("data moved with clock high");
	chk_store_single: assert property (nvm_store_o |=> !nvm_store_o)
		else $error("store pulse too long");
	chk_store_unlocked: assert property (nvm_store_o |-> !locked_o)
		else $error("store while locked");
	chk_locked_hold: assert property (init_done && locked_o && $past(locked_o)
		|-> $stable(cfg_o.turn_on_delay))
		else $error("locked register changed");
	chk_switch_hold: assert property (init_done && switching_en_i && $past(switching_en_i)
		|-> $stable(cfg_o.ton_ramp))
		else $error("guarded register changed");
	chk_staged_hold: assert property (sw_run ##0 init_done |-> $stable(cfg_o.vr_addr))
		else $error("staged field applied early");
	chk_addr_fixed: assert property (init_done |-> $stable(cfg_o.prog_addr))
		else $error("active address changed");
endmodule
bind i2c_config_access i2c_config_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
	.switching_en_i(switching_en_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
	.nvm_store_o(nvm_store_o), .cfg_o(cfg_o), .locked_o(locked_o));

//--- i2c_ctl_model.sv
`timescale 1ns/1ps
// bus controller, open drain: sda_pull_o high pulls data low
module i2c_ctl_model
(
	input  wire logic clk_i,     // paces the bus
	input  wire logic sda_i,     // resolved data wire
	output logic      scl_o,     // bus clock, idle high
	output logic      sda_pull_o // pulls data low
);
	initial
	begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	// wait n falling core edges
	task automatic q(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// start or repeated start: data falls with clock high
	task automatic start();
		q(2);
		sda_pull_o = 1'b0;
		q(6);
		scl_o = 1'b1;
		q(8);
		sda_pull_o = 1'b1;
		q(8);
		scl_o = 1'b0;
	endtask
	// stop: data rises with clock high
	task automatic stop();
		q(2);
		sda_pull_o = 1'b1;
		q(6);
		scl_o = 1'b1;
		q(8);
		sda_pull_o = 1'b0;
		q(8);
	endtask
	// data moves only with clock low, sampled before the fall
	task automatic bit_x(input logic b, output logic s);
		q(2);
		sda_pull_o = !b;
		q(6);
		scl_o = 1'b1;
		q(8);
		s = sda_i;
		scl_o = 1'b0;
	endtask
	// byte msb first, then ninth bit; a_o low means acknowledged
	task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] r,
		output logic a_o);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r[i]);
		bit_x(a_in, a_o);
	endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench import i2c_config_pkg::*;;
	localparam logic [6:0] DEV = 7'h72; // strap code 2
	localparam reg_set_t NVM = {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h00, 8'h07, 8'h2A,
		8'h08, 8'h09};
	localparam logic [6:0][7:0] GUARD = {ADDR_NVM_RESTORE, ADDR_TURN_ON_DELAY, ADDR_TON_RAMP,
		ADDR_TURN_OFF_DELAY, ADDR_TOFF_RAMP, ADDR_MAX_HI, ADDR_MAX_LO};
	logic       clk;         // core clock
	logic       rst_n;       // reset, active low
	logic       sw_en;       // switching running
	logic       scl;         // bus clock
	logic       pull;        // controller pulls data
	logic       sda_oe_n;    // device pulls data
	logic       sda;         // data wire with pull-up
	logic       store;       // store pulse
	logic [7:0] st_addr;     // address seen at store
	reg_set_t   cfg;         // settings in effect
	reg_set_t   wdata;       // settings to store
	logic       locked;      // lock flag
	logic       aon;         // always-on turn-on source
	reg_set_t   nvm;         // nvm contents seen by the block
	int         miscompares = 0;
	int         n_tests = 0;
	int         n_store = 0; // store pulses
	int         cyc = 0;     // cycle count for timeout
	assign sda = !(pull || !sda_oe_n);
	i2c_config_access u_dut (.clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(),
		.sda_oe_n_o(sda_oe_n), .strap_code_i(4'h2), .switching_en_i(sw_en), .always_on_i(aon),
		.nvm_rdata_i(nvm), .nvm_store_o(store), .nvm_wdata_o(wdata), .cfg_o(cfg),
		.locked_o(locked));
	i2c_ctl_model u_ctl (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// store pulse monitor and timeout
	always @(posedge clk)
	begin
		cyc++;
		if (store === 1'b1)
		begin
			n_store++;
			st_addr = wdata.prog_addr;
		end
		if (cyc == 40000)
		begin
			miscompares++;
			complete_run();
		end
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
		output logic aa, output logic da);
		logic [7:0] r;
		u_ctl.start();
		u_ctl.xfer({a, DIR_WRITE}, 1'b1, r, aa);
		u_ctl.xfer(p, 1'b1, r, da);
		u_ctl.xfer(d, 1'b1, r, da);
		u_ctl.stop(); // no check byte
	endtask
	// write, then check address ack and data ack or nack
	task automatic wrc(input logic [7:0] p, input logic [7:0] d, input logic nak);
		logic aa;
		logic da;
		wr(DEV, p, d, aa, da);
		cmp({6'h00, aa, da}, {7'h00, nak});
	endtask
	task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
		logic [7:0] v;
		logic       a;
		u_ctl.start();
		u_ctl.xfer({DEV, DIR_WRITE}, 1'b1, v, a);
		u_ctl.xfer(p, 1'b1, v, a);
		u_ctl.start();
		u_ctl.xfer({DEV, 1'b1}, 1'b1, v, a);
		cmp({7'h00, a}, 8'h00);
		u_ctl.xfer(8'hFF, 1'b1, v, a);
		u_ctl.stop();
		cmp(v, exp);
	endtask
	task automatic t_locked();
		logic aa;
		logic da;
		wrc(ADDR_TURN_ON_DELAY, 8'h33, 1'b1);
		rdc(ADDR_TURN_ON_DELAY, NVM.turn_on_delay);
		wr(DEV + 7'h01, ADDR_LOCK, 8'hA5, aa, da);
		cmp({7'h00, aa}, 8'h01);
	endtask
	task automatic t_unlock();
		for (int i = 0; i < 3; i++)
			wrc(ADDR_LOCK, LOCK_PASSCODES[i], 1'b0);
		cmp({7'h00, locked}, 8'h00);
		wrc(ADDR_TURN_ON_DELAY, 8'h33, 1'b0);
		cmp(cfg.turn_on_delay, 8'h33);
	endtask
	task automatic t_switch();
		sw_en = 1'b1;
		for (int i = 0; i < 7; i++)
			wrc(GUARD[i], 8'h44, 1'b1);
		cmp(cfg.ton_ramp, NVM.ton_ramp);
		wrc(ADDR_VR_ADDR, 8'h55, 1'b0);
		cmp(cfg.vr_addr, NVM.vr_addr);
		rdc(ADDR_VR_ADDR, 8'h55);
		sw_en = 1'b0;
		repeat (4) @(negedge clk);
		cmp(cfg.vr_addr, 8'h55);
	endtask
	task automatic t_store();
		wrc(ADDR_PROG_ADDR, 8'h7F, 1'b0);
		wrc(ADDR_SYS_CFG, 8'h01, 1'b0);
		rdc(ADDR_PROG_ADDR, 8'h7F);
		cmp({1'b0, cfg.prog_addr[6:0]}, {1'b0, DEV});
		cmp({7'h00, cfg.sys_cfg[SYS_TGT_OVRD_BIT]}, 8'h00);
		cmp(n_store[7:0], 8'h00);
		wrc(ADDR_NVM_STORE, 8'h01, 1'b0);
		cmp(n_store[7:0], 8'h01);
		cmp({1'b0, st_addr[6:0]}, 8'h7F);
	endtask
	// always-on restore skips guarded registers, offset staged under source 01
	task automatic t_restore();
		aon = 1'b1;
		wrc(ADDR_NVM_RESTORE, 8'h00, 1'b0);
		cmp(cfg.turn_on_delay, 8'h33);
		wrc(ADDR_SYS_CFG, 8'h08, 1'b0);
		sw_en = 1'b1;
		wrc(ADDR_OFFSET, 8'h66, 1'b0);
		cmp(cfg.offset, NVM.offset);
		sw_en = 1'b0;
		repeat (4) @(negedge clk);
		cmp(cfg.offset, 8'h66);
	endtask
	// power cycle with override stored and always-on source
	task automatic t_reset();
		nvm.sys_cfg = 8'h01;
		rst_n = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (20) @(negedge clk);
		cmp({7'h00, locked}, 8'h01);
		cmp(cfg.turn_on_delay, 8'h00);
		cmp(cfg.prog_addr, NVM.prog_addr);
	endtask
	task automatic complete_run();
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		rst_n = 1'b0;
		sw_en = 1'b0;
		aon = 1'b0;
		nvm = NVM;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (20) @(negedge clk);
		t_locked();
		t_unlock();
		t_switch();
		t_store();
		t_restore();
		t_reset();
		complete_run();
	end
endmodule
